/* File: logic/spm_avail.sv */
`timescale 1ns/100ps
// Line availability tracker, fed once per second
module spm_avail (
  input wire logic mclk,
  input wire logic reset,
  input wire logic tick,
  input wire logic severe,
  output logic unavail
);
  import spm_pkg::*;

  spm_avail_t state_r;
  logic [3:0] run_r;

  // Count runs of severe (or clean) seconds; switch state after ten in a row
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= SPM_AVAIL;
      run_r <= 4'h0;
    end else if (tick) begin
      case (state_r)
        SPM_AVAIL: begin
          if (!severe) begin
            run_r <= 4'h0;
          end else if (run_r == UAS_RUN - 4'h1) begin
            state_r <= SPM_UNAVAIL;
            run_r <= 4'h0;
          end else begin
            run_r <= run_r + 4'h1;
          end
        end
        SPM_UNAVAIL: begin
          if (severe) begin
            run_r <= 4'h0;
          end else if (run_r == UAS_RUN - 4'h1) begin
            state_r <= SPM_AVAIL;
            run_r <= 4'h0;
          end else begin
            run_r <= run_r + 4'h1;
          end
        end
        default: begin
          state_r <= SPM_AVAIL;
          run_r <= 4'h0;
        end
      endcase
    end
  end

  assign unavail = (state_r == SPM_UNAVAIL);
endmodule // spm_avail

/* File: logic/spm_counters.sv */
`timescale 1ns/100ps
module spm_counters #(
  parameter int TICK_PERIOD = spm_pkg::TICK_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input spm_pkg::spm_rx_t rx,
  input spm_pkg::spm_prot_t prot,
  input wire logic [31:0] sect_k,
  input wire logic [31:0] line_k,
  input wire logic period_start,
  output spm_pkg::spm_counts_t counts,
  output logic second_tick,
  output logic line_unavailable
);
  import spm_pkg::*;

  logic tick;
  logic [CNT_W-1:0] sect_sec_r;
  logic [CNT_W-1:0] line_sec_r;
  logic sect_def_r;
  logic sef_seen_r;
  logic line_def_r;
  logic fail_r;
  logic on_prot_r;
  logic [B1_W-1:0] b1_add;
  logic [B2_W-1:0] b2_add;
  logic fail_now;
  logic sect_err_sec;
  logic sect_sev_sec;
  logic line_err_sec;
  logic line_sev_sec;
  logic unavail;
  logic switched;
  logic prot_second;

  // Common one-second tick for every per-second decision
  spm_tick #(
    .PERIOD(TICK_PERIOD)
  ) u_tick (
    .mclk(mclk),
    .reset(reset),
    .tick(tick)
  );

  // Clamp parity inputs so a faulty framer cannot over-count
  assign b1_add = (rx.b1_errs > B1_MAX) ? B1_MAX : rx.b1_errs;
  assign b2_add = (rx.b2_errs > B2_MAX) ? B2_MAX : rx.b2_errs;

  // Per-second accumulators, restarted at each tick
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sect_sec_r <= ZERO;
      line_sec_r <= ZERO;
    end else if (tick) begin
      // A frame that lands on the tick opens the new second rather than being lost
      sect_sec_r <= rx.frame_valid ? CNT_W'(b1_add) : ZERO;
      line_sec_r <= rx.frame_valid ? CNT_W'(b2_add) : ZERO;
    end else if (rx.frame_valid) begin
      sect_sec_r <= sect_sec_r + CNT_W'(b1_add);
      line_sec_r <= line_sec_r + CNT_W'(b2_add);
    end
  end

  // Defect presence latched across the second; cleared by the tick
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sect_def_r <= 1'b0;
      sef_seen_r <= 1'b0;
      line_def_r <= 1'b0;
    end else if (tick) begin
      sect_def_r <= 1'b0;
      sef_seen_r <= 1'b0;
      line_def_r <= 1'b0;
    end else begin
      sect_def_r <= sect_def_r | rx.sef | rx.los;
      sef_seen_r <= sef_seen_r | rx.sef;
      line_def_r <= line_def_r | rx.ais_l;
    end
  end

  // Second qualification; defects present in the tick cycle itself are included
  assign sect_err_sec = (sect_sec_r != ZERO) || sect_def_r || rx.sef || rx.los;
  assign sect_sev_sec = (sect_sec_r >= sect_k) || sect_def_r || rx.sef || rx.los;
  assign line_err_sec = (line_sec_r != ZERO) || line_def_r || rx.ais_l;
  assign line_sev_sec = (line_sec_r >= line_k) || line_def_r || rx.ais_l;

  // Availability follows consecutive severe seconds
  spm_avail u_avail (
    .mclk(mclk),
    .reset(reset),
    .tick(tick),
    .severe(line_sev_sec),
    .unavail(unavail)
  );

  // Violation counts are running totals of every erred bit
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      counts.section_violation_count <= ZERO;
      counts.line_violation_count <= ZERO;
    end else if (rx.frame_valid) begin
      counts.section_violation_count <= counts.section_violation_count + CNT_W'(b1_add);
      counts.line_violation_count <= counts.line_violation_count + CNT_W'(b2_add);
    end
  end

  // Section second counts
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      counts.section_errored_seconds <= ZERO;
      counts.section_severe_seconds <= ZERO;
      counts.section_framing_severe_seconds <= ZERO;
    end else if (tick) begin
      if (sect_err_sec) begin
        counts.section_errored_seconds <= counts.section_errored_seconds + ONE;
      end
      if (sect_sev_sec) begin
        counts.section_severe_seconds <= counts.section_severe_seconds + ONE;
      end
      // SEF alone decides, whatever LOS or LOF did
      if (sef_seen_r || rx.sef) begin
        counts.section_framing_severe_seconds <= counts.section_framing_severe_seconds + ONE;
      end
    end
  end

  // Line second counts; the unavailable count uses the state at the tick,
  // so the ten qualifying seconds are not back-dated
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      counts.line_errored_seconds <= ZERO;
      counts.line_severe_seconds <= ZERO;
      counts.line_unavailable_seconds <= ZERO;
    end else if (tick) begin
      if (line_err_sec) begin
        counts.line_errored_seconds <= counts.line_errored_seconds + ONE;
      end
      if (line_sev_sec) begin
        counts.line_severe_seconds <= counts.line_severe_seconds + ONE;
      end
      if (unavail) begin
        counts.line_unavailable_seconds <= counts.line_unavailable_seconds + ONE;
      end
    end
  end

  // Failure events counted on the opening edge only
  assign fail_now = rx.ais_l_fail | rx.lower_fail;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fail_r <= 1'b0;
    end else begin
      fail_r <= fail_now;
    end
  end

  // A period reset zeroes the count, but an event still open is not
  // recounted in the new period since only a rising edge adds one
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      counts.line_failure_events <= ZERO;
    end else if (period_start) begin
      counts.line_failure_events <= (fail_now && !fail_r) ? ONE : ZERO;
    end else if (fail_now && !fail_r) begin
      counts.line_failure_events <= counts.line_failure_events + ONE;
    end
  end

  // Protection switch tracking
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      on_prot_r <= 1'b0;
    end else begin
      on_prot_r <= prot.on_protect;
    end
  end

  // With revertive set, any change of the selected line is one transfer, away or back, on either card
  assign switched = prot.revertive && (prot.on_protect != on_prot_r);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      counts.protection_switch_count <= ZERO;
    end else if (switched) begin
      counts.protection_switch_count <= counts.protection_switch_count + ONE;
    end
  end

  // Working line: seconds on protection; protection line: seconds carrying traffic.
  // Traffic on protection with revertive set means the same condition seen from either card.
  assign prot_second = prot.revertive && prot.on_protect;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      counts.protection_switch_duration <= ZERO;
    end else if (tick && prot_second) begin
      counts.protection_switch_duration <= counts.protection_switch_duration + ONE;
    end
  end

  // Ring protection is unsupported, so these variants stay at zero
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      counts.switch_count_working_variant <= ZERO;
      counts.switch_count_span_variant <= ZERO;
      counts.switch_count_ring_variant <= ZERO;
    end else begin
      counts.switch_count_working_variant <= ZERO;
      counts.switch_count_span_variant <= ZERO;
      counts.switch_count_ring_variant <= ZERO;
    end
  end

  assign second_tick = tick;
  assign line_unavailable = unavail;
endmodule // spm_counters

/* File: logic/spm_pkg.sv */
package spm_pkg;
  // Counter widths
  localparam int CNT_W = 32;
  localparam int B1_W = 4;          // 0..8 mismatched bits per frame
  localparam int B2_W = 12;         // 0..8 x N per frame
  localparam int STS_N = 3;         // STS-N order of the port
  localparam logic [B2_W-1:0] B2_MAX = 12'(8 * STS_N);
  localparam logic [B1_W-1:0] B1_MAX = 4'h8;
  // Consecutive seconds to enter or leave unavailable state
  localparam logic [3:0] UAS_RUN = 4'hA;
  // Tick divider: one second at 100 MHz
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_CYC = CLK_HZ * 1;
  localparam logic [CNT_W-1:0] ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] ONE = 32'h0000_0001;

  // Per-frame parity results and defect levels from the receive framer
  typedef struct packed {
    logic frame_valid;
    logic [B1_W-1:0] b1_errs;
    logic [B2_W-1:0] b2_errs;
    logic sef;
    logic los;
    logic ais_l;
    logic lower_fail;
    logic ais_l_fail;
  } spm_rx_t;

  // Protection configuration and state
  typedef struct packed {
    logic revertive;
    logic is_protect_card;
    logic on_protect;
  } spm_prot_t;

  typedef struct packed {
    logic [CNT_W-1:0] section_violation_count;
    logic [CNT_W-1:0] section_errored_seconds;
    logic [CNT_W-1:0] section_severe_seconds;
    logic [CNT_W-1:0] section_framing_severe_seconds;
    logic [CNT_W-1:0] line_violation_count;
    logic [CNT_W-1:0] line_errored_seconds;
    logic [CNT_W-1:0] line_severe_seconds;
    logic [CNT_W-1:0] line_unavailable_seconds;
    logic [CNT_W-1:0] line_failure_events;
    logic [CNT_W-1:0] protection_switch_count;
    logic [CNT_W-1:0] protection_switch_duration;
    logic [CNT_W-1:0] switch_count_working_variant;
    logic [CNT_W-1:0] switch_count_span_variant;
    logic [CNT_W-1:0] switch_count_ring_variant;
  } spm_counts_t;

  typedef enum logic [1:0] {
    SPM_AVAIL = 2'h1,
    SPM_UNAVAIL = 2'h2
  } spm_avail_t;
endpackage

/* File: logic/spm_tick.sv */
`timescale 1ns/100ps
// One-second tick divider
module spm_tick #(
  parameter int PERIOD = spm_pkg::TICK_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  output logic tick
);
  import spm_pkg::*;

  logic [31:0] cnt_r;

  // Free-running count, one pulse per period
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_r <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (cnt_r == 32'(PERIOD - 1)) begin
      cnt_r <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule // spm_tick

/* File: sim/spm_counters_chk.sv */
`timescale 1ns/100ps
// Port-level checks on the counter block
module spm_counters_chk #(
  parameter int TICK_PERIOD = 20
) (
  input wire logic mclk,
  input wire logic reset,
  input spm_pkg::spm_rx_t rx,
  input spm_pkg::spm_prot_t prot,
  input wire logic period_start,
  input spm_pkg::spm_counts_t counts,
  input wire logic second_tick,
  input wire logic line_unavailable
);
  import spm_pkg::*;
  logic [CNT_W-1:0] b1_add;
  logic [CNT_W-1:0] b2_add;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Oversize reports saturate at the per-frame ceiling
  assign b1_add = !rx.frame_valid ? ZERO : (rx.b1_errs > B1_MAX) ? CNT_W'(B1_MAX) : CNT_W'(rx.b1_errs);
  assign b2_add = !rx.frame_valid ? ZERO : (rx.b2_errs > B2_MAX) ? CNT_W'(B2_MAX) : CNT_W'(rx.b2_errs);
  // Failure opens on the rising level; a second closes on the tick
  sequence s_fail_open;
    $rose(rx.ais_l_fail | rx.lower_fail);
  endsequence
  sequence s_unavail_sec;
    second_tick && line_unavailable;
  endsequence
  AST_SECT_VIOL: assert property (
    ##1 counts.section_violation_count == $past(counts.section_violation_count) + $past(b1_add))
    else $error("section violation sum wrong");
  AST_LINE_VIOL: assert property (
    ##1 counts.line_violation_count == $past(counts.line_violation_count) + $past(b2_add))
    else $error("line violation sum wrong");
  AST_SECT_DEFECT: assert property (
    second_tick && rx.sef |=> counts.section_severe_seconds == $past(counts.section_severe_seconds) + ONE
      && counts.section_errored_seconds == $past(counts.section_errored_seconds) + ONE
      && counts.section_framing_severe_seconds == $past(counts.section_framing_severe_seconds) + ONE)
    else $error("framing defect second not counted");
  AST_LINE_AIS: assert property (
    second_tick && rx.ais_l |=> counts.line_severe_seconds == $past(counts.line_severe_seconds) + ONE
      && counts.line_errored_seconds == $past(counts.line_errored_seconds) + ONE)
    else $error("line alarm second not counted");
  AST_UNAV_SEC: assert property (
    s_unavail_sec |=> counts.line_unavailable_seconds == $past(counts.line_unavailable_seconds) + ONE)
    else $error("unavailable second not counted");
  AST_FAIL_OPEN: assert property (
    s_fail_open |=> counts.line_failure_events ==
      ($past(period_start) ? ONE : $past(counts.line_failure_events) + ONE))
    else $error("failure event not counted");
  // A new period drops events that opened before it, even if still open
  AST_PERIOD_CLR: assert property (
    period_start && !$rose(rx.ais_l_fail | rx.lower_fail) |=> counts.line_failure_events == ZERO)
    else $error("failure count not restarted at period start");
  AST_SWITCH: assert property (
    prot.revertive && $changed(prot.on_protect) |=> counts.protection_switch_count == $past(counts.protection_switch_count) + ONE)
    else $error("switch not counted");
  AST_DURATION: assert property (
    second_tick && prot.revertive && prot.on_protect |=> counts.protection_switch_duration == $past(counts.protection_switch_duration) + ONE)
    else $error("switched second not counted");
  AST_VARIANTS: assert property (
    (counts.switch_count_working_variant | counts.switch_count_span_variant | counts.switch_count_ring_variant) == ZERO)
    else $error("variant counter moved");
endmodule // spm_counters_chk

bind spm_counters spm_counters_chk #(.TICK_PERIOD(TICK_PERIOD)) u_chk (.mclk(mclk), .reset(reset), .rx(rx),
  .prot(prot), .period_start(period_start), .counts(counts), .second_tick(second_tick),
  .line_unavailable(line_unavailable));

/* File: sim/spm_lte_model.sv */
`timescale 1ns/100ps
// Far-end line equipment: frames on request, defects and failures as levels
module spm_lte_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic send,
  input wire logic [3:0] b1,
  input wire logic [11:0] b2,
  input wire logic [4:0] dfx,
  output spm_pkg::spm_rx_t rx
);
  import spm_pkg::*;
  // Parity fields are inverted between frames so a lazy sampler is caught
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx <= '0;
    end else begin
      rx.frame_valid <= send;
      rx.b1_errs <= send ? b1 : ~rx.b1_errs;
      rx.b2_errs <= send ? b2 : ~rx.b2_errs;
      {rx.sef, rx.los, rx.ais_l, rx.lower_fail, rx.ais_l_fail} <= dfx;
    end
  end
endmodule // spm_lte_model

/* File: sim/tb_sonet_section_line_pm_counters.sv */
`timescale 1ns/100ps
// Self-checking bench: one note of expected totals per second
module tb_sonet_section_line_pm_counters;
  import spm_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic send = 1'b0;
  logic [3:0] b1 = 4'h0;
  logic [11:0] b2 = 12'h000;
  logic [4:0] dfx = 5'h00;
  logic period_start = 1'b0;
  logic [31:0] sect_k = 32'h0000_0001;
  logic [31:0] line_k = 32'h0000_0001;
  spm_prot_t prot = '0;
  spm_rx_t rx;
  spm_counts_t counts;
  spm_counts_t ex = '0;
  spm_counts_t e_c;
  spm_counts_t note_q[$];
  logic una_q[$];
  logic e_u;
  logic second_tick;
  logic line_unavailable;
  logic una = 1'b0;
  logic prev_fail = 1'b0;
  logic [2:0] prev_d = 3'h0;
  int sev_run = 0;
  int clean_run = 0;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;

  spm_lte_model u_lte (.mclk(mclk), .reset(reset), .send(send), .b1(b1), .b2(b2), .dfx(dfx), .rx(rx));
  spm_counters #(.TICK_PERIOD(20)) DUT (.mclk(mclk), .reset(reset), .rx(rx), .prot(prot), .sect_k(sect_k),
    .line_k(line_k), .period_start(period_start), .counts(counts), .second_tick(second_tick),
    .line_unavailable(line_unavailable));

  task automatic check(input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] want);
    n_checks++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Drive one second, then note the totals it should leave behind
  task automatic one_second(input int mode);
    int sb1;
    int sb2;
    logic [2:0] dq;
    logic [2:0] pr;
    logic sev;
    sb1 = 0;
    sb2 = 0;
    pr = 3'($urandom);
    cyc(1);
    dfx[4:2] = (mode == 1) ? 3'h1 : (mode == 2) ? 3'h0 : 3'($urandom) & 3'($urandom);
    dfx[1:0] = 2'($urandom);
    prot.revertive = pr[2];
    prot.is_protect_card = 1'($urandom); // Card role must not change any count
    if ((dfx[1] | dfx[0]) && !prev_fail) ex.line_failure_events++;
    prev_fail = dfx[1] | dfx[0];
    // Defects linger one cycle into the next second through the far end
    dq = dfx[4:2] | prev_d;
    prev_d = dfx[4:2];
    cyc(1);
    if (prot.revertive && pr[0] !== prot.on_protect) ex.protection_switch_count++;
    prot.on_protect = pr[0];
    for (int i = 0; i < 5; i++) begin
      send = 1'($urandom);
      b1 = 4'($urandom);
      b2 = (mode == 2) ? 12'h000 : 12'($urandom % 32);
      sb1 += !send ? 0 : (b1 > 8) ? 8 : int'(b1);
      sb2 += !send ? 0 : (b2 > 24) ? 24 : int'(b2);
      cyc(1);
    end
    send = 1'b0;
    period_start = pr[1];
    cyc(1);
    period_start = 1'b0;
    if (pr[1]) ex.line_failure_events = ZERO;
    ex.section_violation_count += CNT_W'(sb1);
    ex.line_violation_count += CNT_W'(sb2);
    sev = dq[0] || sb2 >= line_k;
    if (sb1 > 0 || dq[2] || dq[1]) ex.section_errored_seconds++;
    if (sb1 >= sect_k || dq[2] || dq[1]) ex.section_severe_seconds++;
    if (dq[2]) ex.section_framing_severe_seconds++;
    if (sb2 > 0 || dq[0]) ex.line_errored_seconds++;
    if (sev) ex.line_severe_seconds++;
    if (una) ex.line_unavailable_seconds++;
    sev_run = sev ? sev_run + 1 : 0;
    clean_run = sev ? 0 : clean_run + 1;
    if (!una && sev_run >= 10) una = 1'b1;
    else if (una && clean_run >= 10) una = 1'b0;
    if (prot.revertive && prot.on_protect) ex.protection_switch_duration++;
    note_q.push_back(ex);
    una_q.push_back(una);
    do cyc(1); while (second_tick !== 1'b1);
  endtask

  task automatic run_phase(input int n, input int mode);
    for (int s = 0; s < n; s++) one_second(mode);
    $display("Test phase %0d done after %0d seconds", mode, n);
  endtask

  initial begin
    forever #5 mclk = ~mclk;
  end

  // Hang guard at 2500 cycles, about 125 seconds of twenty cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2500) begin
      failures++;
      summarize();
    end
  end

  // At each closed second compare all totals with the oldest note
  always @(posedge mclk) begin
    if (second_tick === 1'b1 && note_q.size() > 0) begin
      #2;
      e_c = note_q.pop_front();
      e_u = una_q.pop_front();
      for (int i = 0; i < 14; i++) check(counts[i*CNT_W +: CNT_W], e_c[i*CNT_W +: CNT_W]);
      check(CNT_W'(line_unavailable), CNT_W'(e_u));
    end
  end

  // Random seconds, a severe run to go unavailable, a clean run back
  initial begin
    void'($urandom(22));
    sect_k = 32'(1 + $urandom % 16);
    line_k = 32'(1 + $urandom % 60);
    repeat (20) @(posedge mclk);
    #1;
    reset = 1'b0;
    do cyc(1); while (second_tick !== 1'b1);
    run_phase(10, 0);
    run_phase(12, 1);
    run_phase(12, 2);
    run_phase(16, 0);
    cyc(3);
    summarize();
  end
endmodule // tb_sonet_section_line_pm_counters
